// ### hdl/ldac_top.sv
// Control logic of the 5-bit ladder reference converter.
// Assumes a register master on clk and a pin pad whose level passes a synchroniser here.
// Overview of operation
// - Converter stays off until enable bit is set; clearing it turns off.
// - Five-bit level code selects one of 32 ladder taps, zero lowest.
// - Ladder top switches among external pin, supply and fixed buffer; bottom grounded.
// - Output level goes to comparator input, ADC channel and reference pin.
// - Pin output enable connects voltage and disables driver, pull-up, input buffer.
// - Digital read of the reference pin returns zero while it carries voltage.
// - Wake from sleep leaves the first control register unchanged.
// - Reset clears enable, pin output enable and level code.
// - Source select 00 supply, 01 external pin, 10 fixed buffer, 11 reserved.
// - Reg0 bits 7,5,3:2; reg1 bits 4:0; unimplemented bits read zero.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module ldac_top
	import ldac_pkg::*;
(
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Register port
	input wire ldac_pkg::ldac_bus_req_type bus_req,
	output logic [7:0] rdata,
	// Power events
	input wire sleep_wake,
	// Reference pin
	input wire pin_level,
	output logic pin_digital_in,
	output logic pin_out_n_oe,
	output ldac_pkg::ldac_pin_ctl_type pin_ctl,
	// Analog controls
	output ldac_pkg::ldac_analog_type analog,
	output logic [4:0] comparator_ref_level,
	output logic [4:0] adc_channel_level
);
	logic enable_q;
	logic pin_oe_q;
	ldac_source_type pss_q;
	logic [4:0] code_q;
	logic [7:0] rdata_q;
	logic pin_sync1_q;
	logic pin_sync2_q;
	logic pin_in_q;
	logic pin_oe_n_q;
	ldac_pin_ctl_type pin_ctl_q;
	ldac_analog_type analog_q;
	logic [4:0] cmp_q;
	logic [4:0] adc_q;
	logic sw_supply;
	logic sw_ext;
	logic sw_fixed;
	logic wr0;
	logic wr1;

	assign wr0 = bus_req.wr && (bus_req.addr == LDAC_ADDR_REG0);
	assign wr1 = bus_req.wr && (bus_req.addr == LDAC_ADDR_REG1);

	// Wake has no path into these flops, so the settings survive sleep
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_q <= LDAC_RESET_REG0[LDAC_BIT_ENABLE];
			pin_oe_q <= LDAC_RESET_REG0[LDAC_BIT_PIN_OE];
			pss_q <= ldac_source_type'(LDAC_RESET_REG0[LDAC_PSS_MSB:LDAC_PSS_LSB]);
		end else if (wr0) begin
			enable_q <= bus_req.wdata[LDAC_BIT_ENABLE];
			pin_oe_q <= bus_req.wdata[LDAC_BIT_PIN_OE];
			pss_q <= ldac_source_type'(bus_req.wdata[LDAC_PSS_MSB:LDAC_PSS_LSB]);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			code_q <= LDAC_RESET_CODE;
		end else if (wr1) begin
			code_q <= bus_req.wdata[LDAC_CODE_MSB:0];
		end
	end

	a_write_applies: assert property (@(posedge clk) disable iff (!arst_n)
		wr0 |=> enable_q == $past(bus_req.wdata[LDAC_BIT_ENABLE]))
		else $error("reg0 write not applied");
	a_code_applies: assert property (@(posedge clk) disable iff (!arst_n)
		wr1 |=> code_q == $past(bus_req.wdata[LDAC_CODE_MSB:0]))
		else $error("reg1 write not applied");
	a_sleep_keeps: assert property (@(posedge clk) disable iff (!arst_n)
		sleep_wake && !wr0 |=> $stable(enable_q) && $stable(pin_oe_q) && $stable(pss_q))
		else $error("wake changed reg0");
	a_reset_clears: assert property (@(posedge clk)
		!arst_n |=> !enable_q && !pin_oe_q && code_q == LDAC_RESET_CODE)
		else $error("reset left converter set");

	// Read data valid the cycle after the strobe only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
		end else if (bus_req.rd) begin
			if (bus_req.addr == LDAC_ADDR_REG0) begin
				rdata_q <= {enable_q, 1'b0, pin_oe_q, 1'b0, pss_q, 2'b00};
			end else begin
				rdata_q <= {3'b000, code_q};
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign rdata = rdata_q;
	a_read_layout: assert property (@(posedge clk) disable iff (!arst_n)
		bus_req.rd && bus_req.addr == LDAC_ADDR_REG1 |=> rdata[7:5] == 3'b000
		&& rdata[4:0] == $past(code_q))
		else $error("reg1 read wrong");
	a_reg0_layout: assert property (@(posedge clk) disable iff (!arst_n)
		bus_req.rd && bus_req.addr == LDAC_ADDR_REG0 |=> rdata[6] == 1'b0
		&& rdata[4] == 1'b0 && rdata[1:0] == 2'b00
		&& rdata[7] == $past(enable_q) && rdata[5] == $past(pin_oe_q))
		else $error("reg0 read wrong");
	a_read_idle: assert property (@(posedge clk) disable iff (!arst_n)
		!bus_req.rd |=> rdata == 8'h00)
		else $error("read data outside read cycle");

	ldac_src_decode u_src_decode (
		.sel(pss_q),
		.top_supply(sw_supply),
		.top_ext_pin(sw_ext),
		.top_fixed_buf(sw_fixed)
	);

	// Analog switches and consumers follow settings one flop later
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			analog_q <= '0;
			cmp_q <= 5'h00;
			adc_q <= 5'h00;
		end else begin
			analog_q.active <= enable_q;
			analog_q.level <= code_q;
			analog_q.top_supply <= sw_supply;
			analog_q.top_ext_pin <= sw_ext;
			analog_q.top_fixed_buf <= sw_fixed;
			cmp_q <= enable_q ? code_q : 5'h00;
			adc_q <= enable_q ? code_q : 5'h00;
		end
	end
	assign analog = analog_q;
	assign comparator_ref_level = cmp_q;
	assign adc_channel_level = adc_q;
	a_code_to_taps: assert property (@(posedge clk) disable iff (!arst_n)
		wr1 |-> ##2 analog.level == $past(bus_req.wdata[4:0], 2))
		else $error("level code not on ladder");
	a_active_follows: assert property (@(posedge clk) disable iff (!arst_n)
		!enable_q ##1 !enable_q |-> !analog.active)
		else $error("converter active while off");
	a_source_onehot: assert property (@(posedge clk) disable iff (!arst_n)
		$past(pss_q) == LDAC_SRC_EXT_PIN |-> analog.top_ext_pin && !analog.top_supply
		&& !analog.top_fixed_buf)
		else $error("source decode wrong");
	a_top_select: assert property (@(posedge clk) disable iff (!arst_n)
		$past(arst_n) |-> analog.top_supply == ($past(pss_q) == LDAC_SRC_SUPPLY)
		&& analog.top_fixed_buf == ($past(pss_q) == LDAC_SRC_FIXED_BUF))
		else $error("ladder top source wrong");
	a_reserved_open: assert property (@(posedge clk) disable iff (!arst_n)
		$past(pss_q) == LDAC_SRC_RESERVED |-> !analog.top_supply && !analog.top_ext_pin
		&& !analog.top_fixed_buf)
		else $error("reserved source closed a switch");
	a_consumers_level: assert property (@(posedge clk) disable iff (!arst_n)
		$past(enable_q) |-> comparator_ref_level == $past(code_q)
		&& adc_channel_level == $past(code_q))
		else $error("consumer level wrong");
	a_consumers_off: assert property (@(posedge clk) disable iff (!arst_n)
		!$past(enable_q) |-> comparator_ref_level == 5'h00 && adc_channel_level == 5'h00)
		else $error("consumer level while off");

	// Pin level is asynchronous; first flop feeds only the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_sync1_q <= 1'b0;
			pin_sync2_q <= 1'b0;
		end else begin
			pin_sync1_q <= pin_level;
			pin_sync2_q <= pin_sync1_q;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_in_q <= 1'b0;
			pin_ctl_q <= '0;
		end else begin
			pin_in_q <= pin_oe_q ? 1'b0 : pin_sync2_q;
			pin_ctl_q.analog_connect <= pin_oe_q;
			pin_ctl_q.driver_disable <= pin_oe_q;
			pin_ctl_q.pullup_disable <= pin_oe_q;
			pin_ctl_q.input_disable <= pin_oe_q;
		end
	end
	assign pin_digital_in = pin_in_q;
	assign pin_ctl = pin_ctl_q;

	// Enable is active low: low means this block owns the pin
	// Own flop, so the pad enable is high through reset and never glitches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_oe_n_q <= ~LDAC_RESET_REG0[LDAC_BIT_PIN_OE];
		end else begin
			pin_oe_n_q <= ~pin_oe_q;
		end
	end
	assign pin_out_n_oe = pin_oe_n_q;

	a_pin_reads_zero: assert property (@(posedge clk) disable iff (!arst_n)
		$past(pin_oe_q) |-> pin_digital_in == 1'b0)
		else $error("pin read not zero");
	a_pin_takeover: assert property (@(posedge clk) disable iff (!arst_n)
		pin_ctl.analog_connect |-> pin_ctl.driver_disable && pin_ctl.pullup_disable
		&& pin_ctl.input_disable && !pin_out_n_oe)
		else $error("pin not taken over");
	a_pin_release: assert property (@(posedge clk) disable iff (!arst_n)
		!pin_ctl.analog_connect |-> pin_out_n_oe && !pin_ctl.driver_disable
		&& !pin_ctl.pullup_disable && !pin_ctl.input_disable)
		else $error("pin held while released");
	a_pin_follows: assert property (@(posedge clk) disable iff (!arst_n)
		$past(arst_n) |-> pin_ctl.analog_connect == $past(pin_oe_q))
		else $error("pin takeover late");
	a_reset_pin_free: assert property (@(posedge clk)
		!arst_n |=> !pin_ctl.analog_connect && pin_out_n_oe && !analog.active)
		else $error("reset left pin taken");
endmodule

// ### hdl/ldac_pkg.sv
// Package for the ladder converter control: register map, fields, resets, enums.
// Assumes an 8-bit register port with one-cycle read latency.
package ldac_pkg;
	localparam logic [0:0] LDAC_ADDR_REG0 = 1'h0;
	localparam logic [0:0] LDAC_ADDR_REG1 = 1'h1;
	localparam int LDAC_BIT_ENABLE = 7;
	localparam int LDAC_BIT_PIN_OE = 5;
	localparam int LDAC_PSS_LSB = 2;
	localparam int LDAC_PSS_MSB = 3;
	localparam int LDAC_CODE_MSB = 4;
	localparam logic [7:0] LDAC_RESET_REG0 = 8'h00;
	localparam logic [4:0] LDAC_RESET_CODE = 5'h00;
	localparam logic [7:0] LDAC_REG0_MASK = 8'hAC;

	typedef enum logic [1:0] {
		LDAC_SRC_SUPPLY = 2'b00,
		LDAC_SRC_EXT_PIN = 2'b01,
		LDAC_SRC_FIXED_BUF = 2'b10,
		LDAC_SRC_RESERVED = 2'b11
	} ldac_source_type;

	typedef struct packed {
		logic [0:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ldac_bus_req_type;

	typedef struct packed {
		logic active;
		logic [4:0] level;
		logic top_supply;
		logic top_ext_pin;
		logic top_fixed_buf;
	} ldac_analog_type;

	typedef struct packed {
		logic analog_connect;
		logic driver_disable;
		logic pullup_disable;
		logic input_disable;
	} ldac_pin_ctl_type;
endpackage

// ### hdl/ldac_src_decode.sv
// Decodes the positive source select into one-hot ladder top switches.
// Assumes a registered select from the same clock domain.
`timescale 1ns/1ps
module ldac_src_decode
	import ldac_pkg::*;
(
	// Select in
	input wire ldac_pkg::ldac_source_type sel,
	// Switches out
	output logic top_supply,
	output logic top_ext_pin,
	output logic top_fixed_buf
);
	always_comb begin
		top_supply = 1'b0;
		top_ext_pin = 1'b0;
		top_fixed_buf = 1'b0;
		// Reserved code closes no switch, so the ladder top floats safely
		unique case (sel)
			LDAC_SRC_SUPPLY: top_supply = 1'b1;
			LDAC_SRC_EXT_PIN: top_ext_pin = 1'b1;
			LDAC_SRC_FIXED_BUF: top_fixed_buf = 1'b1;
			LDAC_SRC_RESERVED: ;
		endcase
	end
endmodule

// ### verification/test_ldac_top.sv
// Self-checking bench for the ladder converter control block.
// Assumes the register port contract: one-cycle strobes, read data one cycle later.
`timescale 1ns/1ps
module test_ldac_top;
	import ldac_pkg::*;
	logic clk;
	logic arst_n;
	logic sleep_wake;
	logic pin_level;
	ldac_bus_req_type bus_req;
	logic [7:0] rdata;
	logic pin_digital_in;
	logic pin_out_n_oe;
	ldac_pin_ctl_type pin_ctl;
	ldac_analog_type analog;
	logic [4:0] comparator_ref_level;
	logic [4:0] adc_channel_level;
	int failures;
	int num_checks;
	int seed;
	logic [7:0] m0;
	logic [7:0] m1;
	logic [7:0] v;

	ldac_top dut_u (.clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
		.sleep_wake(sleep_wake), .pin_level(pin_level), .pin_digital_in(pin_digital_in),
		.pin_out_n_oe(pin_out_n_oe), .pin_ctl(pin_ctl), .analog(analog),
		.comparator_ref_level(comparator_ref_level), .adc_channel_level(adc_channel_level));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Model keeps only implemented bits
	task wr(input logic a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
		if (a) m1 = d & 8'h1F;
		else m0 = d & LDAC_REG0_MASK;
	endtask

	task rd(input logic a, input logic [7:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 check("rdata", rdata, exp);
		@(posedge clk);
		#1 check("rdata idle", rdata, 8'h00);
	endtask

	function logic [7:0] exp_sw();
		return {m0[7], m0[3:2] == 2'b00, m0[3:2] == 2'b01, m0[3:2] == 2'b10, {4{m0[5]}}};
	endfunction

	// Three edges so the pad synchroniser has settled too
	task check_all;
		repeat (3) @(posedge clk);
		#1;
		check("switches", {analog.active, analog.top_supply, analog.top_ext_pin,
			analog.top_fixed_buf, pin_ctl}, exp_sw());
		check("pin", {6'h00, pin_out_n_oe, pin_digital_in},
			{6'h00, ~m0[5], pin_level & ~m0[5]});
		check("ladder level", {3'h0, analog.level}, m1);
		check("cmp level", {3'h0, comparator_ref_level}, m0[7] ? m1 : 8'h00);
		check("adc level", {3'h0, adc_channel_level}, m0[7] ? m1 : 8'h00);
	endtask

	// Guard against a hang
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		wrap_up;
	end

	initial begin
		seed = 32'h8f3d5c3b;
		arst_n = 1'b0;
		bus_req = '0;
		sleep_wake = 1'b0;
		pin_level = 1'b1;
		failures = 0;
		num_checks = 0;
		m0 = 8'h00;
		m1 = 8'h00;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		check_all;
		rd(1'b0, 8'h00);
		rd(1'b1, 8'h00);
		// First four cover every source code at full scale, then zero code
		for (int i = 0; i < 28; i++) begin
			v = (i < 4) ? 8'hFF : (i == 4) ? 8'h00 : 8'($random(seed));
			pin_level <= v[4] ^ v[0];
			wr(1'b0, {v[7:4], i[1:0], v[1:0]});
			wr(1'b1, (i < 5) ? v : 8'($random(seed)));
			check_all;
			rd(1'b0, m0);
			rd(1'b1, m1);
		end
		wr(1'b0, 8'hA4);
		wr(1'b0, m0 & 8'h7F);
		@(posedge clk);
		sleep_wake <= 1'b1;
		@(posedge clk);
		sleep_wake <= 1'b0;
		rd(1'b0, m0);
		check_all;
		wr(1'b0, 8'hAC);
		wr(1'b1, 8'h15);
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		m0 = 8'h00;
		m1 = 8'h00;
		check_all;
		rd(1'b0, 8'h00);
		rd(1'b1, 8'h00);
		wrap_up;
	end
endmodule
